//--- hdl/pmw_buf.sv
// Two-entry buffer between the local data source and the PCI data lines.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module pmw_buf
   import pmw_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire pmw_qword_t in_word,
   output logic out_valid,
   input wire logic out_ready,
   output pmw_qword_t out_word
);
   pmw_qword_t mem [0:1];
   logic wr_ptr;
   logic rd_ptr;
   logic [1:0] count;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   // A full buffer still accepts a word in the cycle it hands one out
   assign in_ready = (count != 2'h2) || out_ready;
   assign out_valid = (count != 2'h0);
   assign out_word = mem[rd_ptr];

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
      end else begin
         if (push) begin
            mem[wr_ptr] <= in_word;
            wr_ptr <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule : pmw_buf
`default_nettype wire

//--- hdl/pmw_defs.svh
// Constants of the fast back-to-back 64-bit write sequencer.
// Assumes inclusion by bare name from files under hdl/.
`ifndef PMW_DEFS_SVH
`define PMW_DEFS_SVH
`define PMW_ST_IDLE 4'h0
`define PMW_ST_ADDR_LOAD 4'h1
`define PMW_ST_BUS_XACT 4'h2
`define PMW_ST_BUS_TERM 4'h3
`define PMW_TERM_NORMAL 3'h0
`define PMW_DECIDE_CYCLES 2'h2
`define PMW_BUF_DEPTH 2
`endif

//--- hdl/pmw_pkg.sv
// Types shared by the sequencer and its skid buffer.
// Assumes nothing beyond a SystemVerilog compiler.
package pmw_pkg;
   typedef struct packed {
      logic [63:0] data;
      logic [7:0] be;
   } pmw_qword_t;

   typedef enum logic [2:0] {
      PMW_IDLE = 3'b000,
      PMW_LOAD = 3'b001,
      PMW_ADDR = 3'b010,
      PMW_DECIDE = 3'b011,
      PMW_DATA = 3'b100,
      PMW_TURN = 3'b101,
      PMW_REL = 3'b110
   } pmw_state_t;
endpackage : pmw_pkg

//--- hdl/pmw_seq.sv
// Master sequencer for a 64-bit write burst of a fast back-to-back pair.
// Assumes PCI pins are already synchronous to mclk (PCI clock); a tristate
// wrapper outside resolves each _o/_oe pair onto the bus wire.
// Function
// - drop bus request after frame asserted while wide local request inactive
// - hold frame, irdyn off two cycles after devseln to decide width
// - after decision wide flag follows ack64n; local grant follows PCI grant
// - devseln and local ready last cycle give irdyn and both strobes
// - data phase completes only when irdyn and trdyn both asserted
// - burst counter decrements the cycle after each completed phase
// - after acceptance drive the next buffered word onto ad and cben
// - frame stays asserted while further data phases remain
// - irdyn stays asserted when frame and local ready were asserted last cycle
// - final phase deasserts frame, req64n and both local strobes
// - turnaround releases bus lines, clears counter, reports normal end
// - idle cycle releases irdyn, par and par64
// - wide request and grant last cycle give address-loading state
// - normal termination code reads zero
`timescale 1ns/100ps
`default_nettype none
`include "pmw_defs.svh"
module pmw_seq
   import pmw_pkg::*;
#(
   parameter int BURST_W = 12
) (
   input wire logic mclk,
   input wire logic sys_rst,
   // PCI side
   input wire logic gntn,
   output logic reqn,
   input wire logic devseln,
   input wire logic trdyn,
   input wire logic ack64n,
   output logic frame_o,
   output logic frame_oe,
   output logic req64_o,
   output logic req64_oe,
   output logic irdy_o,
   output logic irdy_oe,
   output logic [63:0] ad_o,
   output logic ad_oe,
   output logic [7:0] cbe_o,
   output logic cbe_oe,
   output logic par_oe,
   output logic par64_oe,
   // Local master side
   input wire logic local_wide_request_n,
   input wire logic local_source_ready_n,
   input wire logic [63:0] local_data,
   input wire logic [7:0] local_byte_enables,
   input wire logic [BURST_W-1:0] requested_beats,
   output logic local_grant_n,
   output logic local_low_word_taken_n,
   output logic local_high_word_taken_n,
   output logic wide_transfer_flag_n,
   output logic [BURST_W-1:0] remaining_beats,
   output logic [3:0] initiator_phase_state,
   output logic [2:0] end_reason_code
);
   ////////////////////////////////////////////////////////////////////////
   pmw_state_t state;
   pmw_state_t next_state;
   logic [1:0] decide_cnt;
   logic devsel_q;
   logic req_q;
   logic gnt_q;
   logic [BURST_W-1:0] fetch_left;
   logic [31:0] addr_lat;
   logic [3:0] cmd_lat;
   logic [BURST_W-1:0] len_lat;
   pmw_qword_t buf_out;
   logic buf_valid;
   logic buf_in_ready;

   wire phase_done = !irdy_o && irdy_oe && !trdyn;
   wire last_phase = (remaining_beats == BURST_W'(1));
   // Prefetch in the address phase and at the end of the decision, so
   // the buffer never runs dry while the source keeps ready asserted
   wire early_take = ((state == PMW_ADDR) && devseln) ||
      ((state == PMW_DECIDE) && (next_state == PMW_DATA));
   wire data_take = (state == PMW_DATA) && devsel_q;
   // take a word in the address phase before devseln, at the end of the decision or once selected, when source ready
   wire take = (early_take || data_take) && !local_source_ready_n &&
      (fetch_left != '0) && buf_in_ready;
   // next word goes out when ad is free or its phase completes
   wire load = (state == PMW_DATA) && buf_valid && (irdy_o || phase_done);
   wire [BURST_W-1:0] left_after = remaining_beats - BURST_W'(phase_done);
   wire load_last = load && (left_after == BURST_W'(1));

   ////////////////////////////////////////////////////////////////////////
   pmw_buf u_buf (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .in_valid(take),
      .in_ready(buf_in_ready),
      .in_word({local_data, local_byte_enables}),
      .out_valid(buf_valid),
      .out_ready(load),
      .out_word(buf_out)
   );

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_state = state;
      case (state)
         // load on wide request plus grant
         PMW_IDLE: if (req_q && gnt_q) next_state = PMW_LOAD;
         PMW_LOAD: if (!gntn) next_state = PMW_ADDR;
         PMW_ADDR: if (!devseln) next_state = PMW_DECIDE;
         PMW_DECIDE: if (decide_cnt == `PMW_DECIDE_CYCLES - 2'h1) next_state = PMW_DATA;
         PMW_DATA: if (phase_done && last_phase) next_state = PMW_TURN;
         PMW_TURN: next_state = PMW_REL;
         PMW_REL: next_state = PMW_IDLE;
         default: next_state = PMW_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state <= PMW_IDLE;
         decide_cnt <= 2'h0;
         devsel_q <= 1'b0;
         req_q <= 1'b0;
         gnt_q <= 1'b0;
         fetch_left <= '0;
         addr_lat <= 32'h0;
         cmd_lat <= 4'h0;
         len_lat <= '0;
      end else begin
         state <= next_state;
         decide_cnt <= (state == PMW_DECIDE) ? decide_cnt + 2'h1 : 2'h0;
         devsel_q <= !devseln;
         req_q <= !local_wide_request_n;
         gnt_q <= !local_grant_n;
         if (state == PMW_LOAD) begin
            fetch_left <= len_lat;
         end else if (take) begin
            fetch_left <= fetch_left - BURST_W'(1);
         end
         if (state == PMW_IDLE && next_state == PMW_LOAD) begin
            addr_lat <= local_data[31:0];
            cmd_lat <= local_byte_enables[3:0];
            len_lat <= requested_beats;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         reqn <= 1'b1;
         frame_o <= 1'b1;
         frame_oe <= 1'b0;
         req64_o <= 1'b1;
         req64_oe <= 1'b0;
         irdy_o <= 1'b1;
         irdy_oe <= 1'b0;
         ad_o <= 64'h0;
         ad_oe <= 1'b0;
         cbe_o <= 8'h0;
         cbe_oe <= 1'b0;
         par_oe <= 1'b0;
         par64_oe <= 1'b0;
         local_grant_n <= 1'b1;
         local_low_word_taken_n <= 1'b1;
         local_high_word_taken_n <= 1'b1;
         wide_transfer_flag_n <= 1'b1;
         remaining_beats <= '0;
         initiator_phase_state <= `PMW_ST_IDLE;
         end_reason_code <= `PMW_TERM_NORMAL;
      end else begin
         local_grant_n <= gntn;
         if (state == PMW_IDLE && !local_wide_request_n) begin
            reqn <= 1'b0;
         end
         // drop request once frame is out without further wide request
         if (frame_oe && !frame_o && local_wide_request_n) begin
            reqn <= 1'b1;
         end
         // strobes pulse with each taken word
         local_low_word_taken_n <= !take;
         local_high_word_taken_n <= !take;
         case (state)
            PMW_IDLE: begin
               irdy_oe <= 1'b0;
               if (next_state == PMW_LOAD) initiator_phase_state <= `PMW_ST_ADDR_LOAD;
            end
            PMW_LOAD: if (!gntn) begin
               frame_o <= 1'b0;
               frame_oe <= 1'b1;
               req64_o <= 1'b0;
               req64_oe <= 1'b1;
               ad_o <= {32'h0, addr_lat};
               ad_oe <= 1'b1;
               cbe_o <= {4'h0, cmd_lat};
               cbe_oe <= 1'b1;
               par_oe <= 1'b1;
               par64_oe <= 1'b1;
               irdy_o <= 1'b1;
               irdy_oe <= 1'b1;
               remaining_beats <= len_lat;
               initiator_phase_state <= `PMW_ST_BUS_XACT;
            end
            PMW_DECIDE: begin
               // frame held, irdyn off while width is judged
               irdy_o <= 1'b1;
               // only ack64n makes the burst wide
               if (next_state == PMW_DATA) wide_transfer_flag_n <= ack64n;
            end
            PMW_DATA: begin
               // irdyn stays low while buffered words remain
               if (load) begin
                  irdy_o <= 1'b0;
                  // put the buffered word on the bus
                  ad_o <= buf_out.data;
                  cbe_o <= buf_out.be;
               end else if (phase_done) begin
                  irdy_o <= 1'b1;
               end
               if (phase_done) remaining_beats <= left_after;
               // frame ends with the last word put out
               if (load_last) begin
                  frame_o <= 1'b1;
                  req64_o <= 1'b1;
               end
               if (phase_done && last_phase) begin
                  frame_oe <= 1'b0;
                  req64_oe <= 1'b0;
                  ad_oe <= 1'b0;
                  cbe_oe <= 1'b0;
                  irdy_o <= 1'b1;
                  remaining_beats <= '0;
                  initiator_phase_state <= `PMW_ST_BUS_TERM;
                  end_reason_code <= `PMW_TERM_NORMAL;
               end
            end
            PMW_TURN: begin
               irdy_oe <= 1'b0;
               par_oe <= 1'b0;
               par64_oe <= 1'b0;
               wide_transfer_flag_n <= 1'b1;
            end
            default: begin
            end
         endcase
      end
   end
endmodule : pmw_seq
`default_nettype wire

//--- tb/pmw_seq_asserts.sv
// Port-level checks of the write sequencer.
// Assumes the single mclk domain with synchronous reset sys_rst.
`timescale 1ns/100ps
`default_nettype none
module pmw_seq_asserts #(
   parameter int BURST_W = 12
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic gntn,
   input wire logic reqn,
   input wire logic devseln,
   input wire logic trdyn,
   input wire logic frame_o,
   input wire logic frame_oe,
   input wire logic req64_oe,
   input wire logic irdy_o,
   input wire logic irdy_oe,
   input wire logic ad_oe,
   input wire logic cbe_oe,
   input wire logic par_oe,
   input wire logic par64_oe,
   input wire logic local_wide_request_n,
   input wire logic local_source_ready_n,
   input wire logic local_grant_n,
   input wire logic local_low_word_taken_n,
   input wire logic local_high_word_taken_n,
   input wire logic [BURST_W-1:0] remaining_beats,
   input wire logic [3:0] initiator_phase_state,
   input wire logic [2:0] end_reason_code
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   wire logic phase_done = irdy_oe && !irdy_o && !trdyn;
   // Last phase: frame still driven but deasserted
   wire logic last_done = phase_done && frame_oe && frame_o;
   a_req_drop: assert property (frame_oe && !frame_o && local_wide_request_n |=> reqn)
      else $error("request kept");
   a_decide_hold: assert property (
      $fell(devseln) |=> (irdy_o && !frame_o && local_low_word_taken_n)[*2])
      else $error("decide cycles broken");
   a_grant_follow: assert property (1'b1 |=> local_grant_n == $past(gntn))
      else $error("local grant lost track");
   a_strobe_pair: assert property (local_low_word_taken_n == local_high_word_taken_n)
      else $error("strobes apart");
   a_irdy_hold: assert property (
      irdy_oe && !irdy_o && !frame_o && !local_source_ready_n |=> !irdy_o)
      else $error("irdy dropped");
   a_count_dec: assert property (
      phase_done |=> remaining_beats == $past(remaining_beats) - 1'b1)
      else $error("count not decremented");
   a_turn_release: assert property (last_done |=> !frame_oe && !req64_oe && !ad_oe &&
      !cbe_oe && irdy_o && remaining_beats == '0 && initiator_phase_state == 4'h3 &&
      end_reason_code == 3'h0)
      else $error("turnaround wrong");
   a_idle_release: assert property (last_done |-> ##2 !irdy_oe && !par_oe && !par64_oe)
      else $error("idle release late");
endmodule : pmw_seq_asserts
`default_nettype wire

//--- tb/pmw_target.sv
// Behavioural 64-bit PCI target, prompt or slow with random stalls.
// Assumes pull-ups: a released frame or irdy reads deasserted.
`timescale 1ns/100ps
`default_nettype none
module pmw_target (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic slow,
   input wire logic frame_o,
   input wire logic frame_oe,
   input wire logic irdy_o,
   input wire logic irdy_oe,
   output logic devseln,
   output logic trdyn,
   output logic ack64n
);
   wire logic frame_w = frame_o || !frame_oe;
   wire logic irdy_w = irdy_o || !irdy_oe;
   logic seen;
   always_ff @(posedge mclk) begin
      // drop all three after the last completed phase
      if (sys_rst || (!irdy_w && !trdyn && frame_w)) begin
         {devseln, trdyn, ack64n, seen} <= 4'he;
      end else if (devseln) begin
         seen <= !frame_w;
         // claim with all three together; slow decode is a cycle later
         if (!frame_w && (seen || !slow))
            {devseln, trdyn, ack64n} <= 3'h0;
      end else if (slow && (trdyn || !irdy_w)) begin
         // An asserted trdyn is held until irdy completes the phase
         trdyn <= 1'($urandom_range(1));
      end
   end
endmodule : pmw_target
`default_nettype wire

//--- tb/test_pmw_seq.sv
// Self-checking bench: random bursts against the target model.
// Assumes pmw_pkg, pmw_seq, pmw_target and the checker compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_pmw_seq;
   import pmw_pkg::*;
   logic mclk = 1'b0, sys_rst = 1'b1, gntn = 1'b1, slow = 1'b0, in_frame = 1'b0;
   logic local_wide_request_n = 1'b1, local_source_ready_n = 1'b1;
   logic [11:0] requested_beats = 12'h000;
   pmw_qword_t word = '0;
   pmw_qword_t taken[$];
   logic [31:0] addr = 32'h0;
   int n_fail = 0, n_tests = 0, n_cyc = 0, phases = 0;
   logic reqn, devseln, trdyn, ack64n, frame_o, frame_oe, req64_o, req64_oe, irdy_o;
   logic irdy_oe, ad_oe, cbe_oe, par_oe, par64_oe, local_grant_n, wide_transfer_flag_n;
   logic local_low_word_taken_n, local_high_word_taken_n;
   logic [63:0] ad_o;
   logic [7:0] cbe_o;
   logic [11:0] remaining_beats;
   logic [3:0] initiator_phase_state;
   logic [2:0] end_reason_code;
   pmw_seq #(.BURST_W(12)) DUT (.mclk, .sys_rst, .gntn, .reqn, .devseln, .trdyn, .ack64n,
      .frame_o, .frame_oe, .req64_o, .req64_oe, .irdy_o, .irdy_oe, .ad_o, .ad_oe, .cbe_o,
      .cbe_oe, .par_oe, .par64_oe, .local_wide_request_n, .local_source_ready_n,
      .local_data(word.data), .local_byte_enables(word.be), .requested_beats,
      .local_grant_n, .local_low_word_taken_n, .local_high_word_taken_n,
      .wide_transfer_flag_n, .remaining_beats, .initiator_phase_state, .end_reason_code);
   pmw_target u_tgt (.mclk, .sys_rst, .slow, .frame_o, .frame_oe, .irdy_o, .irdy_oe,
      .devseln, .trdyn, .ack64n);
   ////////////////////////////////////////////////////////////////////////////////
   always #4 mclk = ~mclk;
   task automatic check(input logic [71:0] seen, input logic [71:0] exp, input string msg);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask : check
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : conclude
   // Words leave the local side when strobed and must reach ad in order
   always @(posedge mclk) begin
      n_cyc++;
      if (n_cyc == 20000) begin
         n_fail++;
         conclude();
      end
      if (frame_oe && !frame_o && !in_frame)
         check({ad_o[31:0], cbe_o[3:0], req64_o}, {addr, 4'h7, 1'b0}, "address phase");
      in_frame = frame_oe && !frame_o;
      if (irdy_oe && !irdy_o && !trdyn) begin
         phases++;
         check({ad_o, cbe_o}, (taken.size() > 0) ? taken.pop_front() : 'x, "data");
         if (frame_o)
            check({wide_transfer_flag_n, req64_o, local_low_word_taken_n}, 3'h3, "end");
      end
   end
   task automatic burst(input int beats, input logic s);
      int t = 0;
      int left = beats;
      slow = s;
      gntn = 1'b0;
      addr = $urandom;
      word = {32'h0, addr, 8'h07};
      requested_beats = 12'(beats);
      local_wide_request_n = 1'b0;
      local_source_ready_n = 1'b0;
      phases = 0;
      while (initiator_phase_state !== 4'h1 && t < 20) begin
         @(negedge mclk);
         t++;
      end
      local_wide_request_n = 1'b1;
      @(negedge mclk);
      word = {$urandom, $urandom, 8'($urandom)};
      while (initiator_phase_state !== 4'h3 && t < 400) begin
         @(negedge mclk);
         t++;
         // next word only once the current one was taken
         if (!local_low_word_taken_n) begin
            taken.push_back(word);
            left--;
            word = {$urandom, $urandom, 8'($urandom)};
         end
         // ready for as long as words remain to be supplied
         local_source_ready_n = (left <= 0);
      end
      check(phases, beats, "phase count");
      gntn = 1'b1;
      repeat (1 + $urandom_range(3)) @(negedge mclk);
      $display("burst of %0d beats done", beats);
   endtask : burst
   initial begin
      void'($urandom(32'hb9cfe73b));
      repeat (5) @(negedge mclk);
      sys_rst = 1'b0;
      // Corners first: single beat, short burst to a slow target, long burst
      burst(1, 1'b0);
      burst(2, 1'b1);
      burst(12, 1'b0);
      for (int i = 0; i < 12; i++)
         burst(1 + $urandom_range(7), 1'($urandom_range(1)));
      conclude();
   end
endmodule : test_pmw_seq
bind pmw_seq pmw_seq_asserts #(.BURST_W(BURST_W)) u_chk (.mclk, .sys_rst, .gntn, .reqn,
   .devseln, .trdyn, .frame_o, .frame_oe, .req64_oe, .irdy_o, .irdy_oe, .ad_oe, .cbe_oe,
   .par_oe, .par64_oe, .local_wide_request_n, .local_source_ready_n, .local_grant_n,
   .local_low_word_taken_n, .local_high_word_taken_n, .remaining_beats,
   .initiator_phase_state, .end_reason_code);
`default_nettype wire
